// ===== design/mbsam_pkg.sv
// shared constants and types for the modbus slave address mapper
package mbsam_pkg;
	// clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int INACT_TIME_MS = 1000;
	localparam int INACT_CYCLES = INACT_TIME_MS * (CLK_HZ / 1000);
	localparam int SCAN_MAX_WORDS = 32;
	// function codes
	localparam logic [7:0] FC_RD_COILS = 8'h01;
	localparam logic [7:0] FC_RD_DISC = 8'h02;
	localparam logic [7:0] FC_RD_HOLD = 8'h03;
	localparam logic [7:0] FC_RD_INREG = 8'h04;
	localparam logic [7:0] FC_WR_COIL = 8'h05;
	localparam logic [7:0] FC_WR_REG = 8'h06;
	localparam logic [7:0] FC_WR_COILS = 8'h0f;
	localparam logic [7:0] FC_WR_REGS = 8'h10;
	// exception codes
	localparam logic [15:0] EXC_ILL_FUNC = 16'h0001;
	localparam logic [15:0] EXC_ILL_ADDR = 16'h0002;
	localparam logic [15:0] EXC_ILL_VALUE = 16'h0003;
	// quantity limits per request
	localparam logic [15:0] QTY_RD_BITS = 16'h07d0;
	localparam logic [15:0] QTY_RD_WORDS = 16'h007d;
	localparam logic [15:0] QTY_WR_BITS = 16'h07b0;
	localparam logic [15:0] QTY_WR_WORDS = 16'h007b;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	// window bases (modbus offsets) and sizes
	localparam logic [16:0] BASE_0 = 17'h00000;
	localparam logic [16:0] BASE_512 = 17'h00200;
	localparam logic [16:0] BASE_3000 = 17'h00bb8;
	localparam logic [16:0] BASE_4000 = 17'h00fa0;
	localparam logic [16:0] BASE_5000 = 17'h01388;
	localparam logic [16:0] BASE_6000 = 17'h01770;
	localparam logic [16:0] BASE_9000 = 17'h02328;
	localparam logic [16:0] BASE_10000 = 17'h02710;
	localparam logic [16:0] SZ_2048 = 17'h00800;
	localparam logic [16:0] SZ_64 = 17'h00040;
	localparam logic [16:0] SZ_13 = 17'h0000d;
	localparam logic [16:0] SZ_KEY = 17'h00000;
	localparam logic [16:0] SZ_512 = 17'h00200;
	localparam logic [16:0] SZ_32 = 17'h00020;
	localparam logic [16:0] SZ_200 = 17'h000c8;
	localparam logic [16:0] SZ_2488 = 17'h009b8;
	localparam logic [16:0] SZ_4096 = 17'h01000;

	typedef enum logic [3:0] {
		SP_NONE, SP_DISC_IN, SP_GLOBAL_INPUT_BITS, SP_SYS_BITS, SP_KEY_BITS,
		SP_OUT_BITS, SP_INT_BITS, SP_TEMP_BITS, SP_GLOBAL_OUTPUT_BITS,
		SP_ANALOG_INPUT_WORDS, SP_GLOBAL_ANALOG_INPUT_WORDS, SP_SYSTEM_WORDS,
		SP_ANALOG_OUTPUT_WORDS, SP_GEN_WORDS, SP_GLOBAL_ANALOG_OUTPUT_WORDS
	} mbsam_space_type;

	typedef enum logic [1:0] {RK_DATA, RK_DONE, RK_EXC} mbsam_rkind_type;

	typedef struct packed {
		logic tcp;
		logic [7:0] unit;
		logic [7:0] func;
		logic [15:0] start;
		logic [15:0] count;
		logic [15:0] value;
	} mbsam_req_type;

	typedef struct packed {
		mbsam_space_type space;
		logic [12:0] index;
	} mbsam_loc_type;

	typedef struct packed {
		logic en;
		logic we;
		mbsam_space_type space;
		logic [12:0] index;
		logic [15:0] wdata;
	} mbsam_mem_type;

	typedef struct packed {
		logic tcp;
		logic ascii;
		mbsam_rkind_type kind;
		logic [7:0] func;
		logic [15:0] data;
	} mbsam_rsp_type;
endpackage

// ===== design/mbsam_mapper.sv
// modbus request interpreter mapping offsets onto internal data spaces
`timescale 1ns/1ps
`default_nettype none
module mbsam_mapper
	import mbsam_pkg::*;
#(
	parameter int INACT_LIMIT = INACT_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// configuration
	input wire logic [7:0] i_own_addr,
	input wire logic i_ascii_mode,
	input wire logic i_tcp_server_en,
	input wire logic i_repeat_en,
	// request in, decoded pdu
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire mbsam_req_type i_req,
	// multi-write data, one element per beat
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [15:0] i_wr_data,
	// internal space access, read data valid in the same cycle as en
	output mbsam_mem_type o_mem,
	input wire logic [15:0] i_mem_rdata,
	// response stream
	output logic o_rsp_valid,
	input wire logic i_rsp_ready,
	output mbsam_rsp_type o_rsp,
	// status
	output logic o_port_active,
	output logic o_link_idle,
	output logic o_exc_call,
	output logic o_fwd,
	// client scan-list check
	input wire logic [7:0] i_scan_count,
	output logic o_scan_ok
);
	typedef enum logic [2:0] {S_IDLE, S_CHECK, S_OP, S_RDATA, S_RSP, S_END} mbsam_state_type;

	mbsam_state_type state_q;
	mbsam_req_type req_q;
	mbsam_rsp_type rsp_q;
	mbsam_mem_type mem_q;
	logic rsp_valid_q, exc_call_q, fwd_q;
	logic [15:0] cnt_q;
	logic [12:0] idx_q;
	logic [31:0] inact_q;

	// true when off lies in [base, base+size)
	function automatic logic in_win(input logic [16:0] off, input logic [16:0] base,
		input logic [16:0] size);
		in_win = (off >= base) && (off < base + size);
	endfunction

	// offset to space and index, same map for either link
	function automatic mbsam_loc_type map_off(input logic [7:0] fc, input logic [16:0] off);
		mbsam_loc_type l;
		l = '{SP_NONE, 13'h0000};
		if (fc == FC_RD_DISC) begin
			if (in_win(off, BASE_0, SZ_2048)) l = '{SP_DISC_IN, off[12:0]};
			else if (in_win(off, BASE_3000, SZ_64)) l = '{SP_GLOBAL_INPUT_BITS, 13'(off - BASE_3000)};
			else if (in_win(off, BASE_4000, SZ_13)) l = '{SP_SYS_BITS, 13'(off - BASE_4000)};
			else if (in_win(off, BASE_5000, SZ_KEY)) l = '{SP_KEY_BITS, 13'(off - BASE_5000)};
		end else if (fc == FC_RD_COILS || fc == FC_WR_COIL || fc == FC_WR_COILS) begin
			if (in_win(off, BASE_0, SZ_2048)) l = '{SP_OUT_BITS, off[12:0]};
			else if (in_win(off, BASE_3000, SZ_2048)) l = '{SP_INT_BITS, 13'(off - BASE_3000)};
			else if (in_win(off, BASE_6000, SZ_2048)) l = '{SP_TEMP_BITS, 13'(off - BASE_6000)};
			else if (in_win(off, BASE_9000, SZ_64)) l = '{SP_GLOBAL_OUTPUT_BITS, 13'(off - BASE_9000)};
		end else if (fc == FC_RD_INREG) begin
			if (in_win(off, BASE_0, SZ_512)) l = '{SP_ANALOG_INPUT_WORDS, off[12:0]};
			else if (in_win(off, BASE_3000, SZ_32))
				l = '{SP_GLOBAL_ANALOG_INPUT_WORDS, 13'(off - BASE_3000)};
			else if (in_win(off, BASE_4000, SZ_200)) l = '{SP_SYSTEM_WORDS, 13'(off - BASE_4000)};
		end else if (fc == FC_RD_HOLD || fc == FC_WR_REG || fc == FC_WR_REGS) begin
			if (in_win(off, BASE_0, SZ_512)) l = '{SP_ANALOG_OUTPUT_WORDS, off[12:0]};
			else if (in_win(off, BASE_512, SZ_2488)) l = '{SP_GEN_WORDS, 13'(off - BASE_512)};
			else if (in_win(off, BASE_3000, SZ_2048)) l = '{SP_GEN_WORDS, 13'(off - BASE_3000)};
			else if (in_win(off, BASE_6000, SZ_32))
				l = '{SP_GLOBAL_ANALOG_OUTPUT_WORDS, 13'(off - BASE_6000)};
			else if (in_win(off, BASE_10000, SZ_4096)) l = '{SP_GEN_WORDS, 13'(off - BASE_10000)};
		end
		map_off = l;
	endfunction

	// request classification
	wire logic fc_single = (req_q.func == FC_WR_COIL) || (req_q.func == FC_WR_REG);
	wire logic fc_multi = (req_q.func == FC_WR_COILS) || (req_q.func == FC_WR_REGS);
	wire logic fc_write = fc_single || fc_multi;
	wire logic fc_bits = (req_q.func == FC_RD_COILS) || (req_q.func == FC_RD_DISC)
		|| (req_q.func == FC_WR_COIL) || (req_q.func == FC_WR_COILS);
	wire logic fc_ok = fc_write || (req_q.func == FC_RD_COILS) || (req_q.func == FC_RD_DISC)
		|| (req_q.func == FC_RD_HOLD) || (req_q.func == FC_RD_INREG);
	wire logic [15:0] eff_count = fc_single ? 16'h0001 : req_q.count;
	wire logic [15:0] qty_max = (req_q.func == FC_WR_COILS) ? QTY_WR_BITS :
		(req_q.func == FC_WR_REGS) ? QTY_WR_WORDS : fc_bits ? QTY_RD_BITS : QTY_RD_WORDS;
	wire logic qty_ok = (eff_count != 16'h0000) && (eff_count <= qty_max)
		&& (req_q.func != FC_WR_COIL || req_q.value == COIL_ON || req_q.value == COIL_OFF);
	wire logic [16:0] last_off = {1'b0, req_q.start} + {1'b0, eff_count} - 17'h00001;
	wire mbsam_loc_type loc_first = map_off(req_q.func, {1'b0, req_q.start});
	wire mbsam_loc_type loc_last = map_off(req_q.func, last_off);
	// range must stay in one window: same space and contiguous index
	wire logic range_ok = (loc_first.space != SP_NONE) && (loc_first.space == loc_last.space)
		&& ({4'h0, loc_last.index - loc_first.index} == 17'(eff_count - 16'h0001));
	wire logic [15:0] exc_code = !fc_ok ? EXC_ILL_FUNC : !qty_ok ? EXC_ILL_VALUE :
		!range_ok ? EXC_ILL_ADDR : 16'h0000;

	// only own address on serial, server enable on tcp
	wire logic req_take = i_req_valid && (state_q == S_IDLE);
	wire logic req_mine = i_req.tcp ? i_tcp_server_en : (i_req.unit == i_own_addr);
	wire logic cnt_last = (cnt_q + 16'h0001) == eff_count;
	wire logic wr_beat = (state_q == S_OP) && (!fc_multi || i_wr_valid);
	wire logic [15:0] wr_value = fc_single ? req_q.value : i_wr_data;
	wire logic [15:0] wr_elem = fc_bits ? {15'h0000, fc_single ? (wr_value == COIL_ON) :
		wr_value[0]} : wr_value;

	// handshake and status outputs
	assign o_req_ready = (state_q == S_IDLE);
	assign o_wr_ready = (state_q == S_OP) && fc_multi;
	assign o_mem = mem_q;
	assign o_rsp = rsp_q;
	assign o_rsp_valid = rsp_valid_q;
	assign o_port_active = (state_q != S_IDLE);
	assign o_link_idle = (inact_q >= 32'(INACT_LIMIT));
	assign o_exc_call = exc_call_q;
	assign o_fwd = fwd_q;
	// client path is independent of the server fsm, so both run at once
	assign o_scan_ok = (i_scan_count != 8'h00) && ({24'h0, i_scan_count} <= SCAN_MAX_WORDS);

	// main sequencer
	always_ff @(posedge i_clk_sys) begin
		exc_call_q <= 1'b0;
		fwd_q <= 1'b0;
		mem_q.en <= 1'b0;
		if (i_srst) begin
			state_q <= S_IDLE;
			req_q <= '0;
			rsp_q <= '0;
			rsp_valid_q <= 1'b0;
			mem_q <= '0;
			cnt_q <= 16'h0000;
			idx_q <= 13'h0000;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (req_take && req_mine) begin
						req_q <= i_req;
						state_q <= S_CHECK;
					end else if (req_take && !i_req.tcp && i_repeat_en) begin
						fwd_q <= 1'b1;
					end
				end
				S_CHECK: begin
					cnt_q <= 16'h0000;
					idx_q <= loc_first.index;
					rsp_q <= '{req_q.tcp, i_ascii_mode, RK_EXC, req_q.func, exc_code};
					if (exc_code != 16'h0000) begin
						rsp_valid_q <= 1'b1;
						exc_call_q <= 1'b1;
						state_q <= S_END;
					end else begin
						state_q <= S_OP;
					end
				end
				S_OP: begin
					if (wr_beat) begin
						mem_q <= '{1'b1, fc_write, loc_first.space, idx_q, wr_elem};
						if (!fc_write) begin
							state_q <= S_RDATA;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
							idx_q <= idx_q + 13'h0001;
							if (cnt_last) begin
								// done only once the last write is issued
								rsp_q.kind <= RK_DONE;
								rsp_q.data <= eff_count;
								rsp_valid_q <= 1'b1;
								state_q <= S_END;
							end
						end
					end
				end
				S_RDATA: begin
					rsp_q.kind <= RK_DATA;
					rsp_q.data <= i_mem_rdata;
					rsp_valid_q <= 1'b1;
					state_q <= S_RSP;
				end
				S_RSP: begin
					if (i_rsp_ready) begin
						cnt_q <= cnt_q + 16'h0001;
						idx_q <= idx_q + 13'h0001;
						if (cnt_last) begin
							rsp_q.kind <= RK_DONE;
							rsp_q.data <= eff_count;
							state_q <= S_END;
						end else begin
							rsp_valid_q <= 1'b0;
							state_q <= S_OP;
						end
					end
				end
				S_END: begin
					if (i_rsp_ready) begin
						rsp_valid_q <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// inactivity timer, restarted by each serial request for this unit
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			inact_q <= 32'h00000000;
		end else if (req_take && req_mine && !i_req.tcp) begin
			inact_q <= 32'h00000000;
		end else if (!o_link_idle) begin
			inact_q <= inact_q + 32'h00000001;
		end
	end

	// checks
	a_bad_func_exc: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(state_q == S_CHECK && !fc_ok) |=> (rsp_valid_q && rsp_q.kind == RK_EXC
		&& rsp_q.data == EXC_ILL_FUNC)) else $error("bad function not refused");
	a_bad_range_exc: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(state_q == S_CHECK && fc_ok && qty_ok && !range_ok) |=> (rsp_q.kind == RK_EXC
		&& rsp_q.data == EXC_ILL_ADDR && o_exc_call)) else $error("bad range not refused");
	a_foreign_silent: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(req_take && !req_mine) |=> (state_q == S_IDLE && !rsp_valid_q))
		else $error("answered a foreign request");
	a_done_after_ops: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(rsp_valid_q && rsp_q.kind == RK_DONE) |-> (cnt_q == eff_count))
		else $error("done before all accesses");
	a_read_latency: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(o_mem.en && !o_mem.we) |=> (rsp_valid_q && rsp_q.kind == RK_DATA
		&& rsp_q.data == $past(i_mem_rdata))) else $error("read data not returned");
	a_coil_value: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(o_mem.en && req_q.func == FC_WR_COIL) |-> (o_mem.we
		&& o_mem.wdata == {15'h0000, req_q.value == COIL_ON})) else $error("coil value wrong");
	a_gen_index: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(o_mem.en && o_mem.space == SP_GEN_WORDS) |-> (o_mem.index < 13'h1000))
		else $error("general word index out of range");
	a_repeat_fwd: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_fwd |-> ($past(i_repeat_en) && $past(state_q) == S_IDLE)) else $error("stray forward");
	a_scan_limit: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_scan_ok |-> (i_scan_count <= 8'h20)) else $error("scan above limit");
	a_tcp_gate: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(req_take && i_req.tcp && i_tcp_server_en) |=> (state_q == S_CHECK))
		else $error("tcp request not served");
endmodule // mbsam_mapper
`default_nettype wire

// ===== verif/mbsam_space_model.sv
// behavioural model of the internal data spaces behind the mapper
`timescale 1ns/1ps
`default_nettype none
module mbsam_space_model
	import mbsam_pkg::*;
(
	// clock
	input wire logic i_clk_sys,
	// access from the mapper
	input wire mbsam_mem_type i_mem,
	output logic [15:0] o_rdata
);
	logic [15:0] idle_q = 16'h0000;
	// filler toggles every cycle, so a capture at the wrong edge never matches
	always @(posedge i_clk_sys) begin
		idle_q <= ~idle_q;
	end
	// word tagged by space and index stands while en is high, so the mapper's
	// capture on the edge after en sees it
	assign o_rdata = (i_mem.en && !i_mem.we) ? {i_mem.space, i_mem.index[11:0]} : idle_q;
endmodule // mbsam_space_model
`default_nettype wire

// ===== verif/tb_mbsam_mapper.sv
// self-checking bench for the modbus offset mapper
`timescale 1ns/1ps
`default_nettype none
module tb_mbsam_mapper
	import mbsam_pkg::*;
;
	// short inactivity limit keeps the idle test quick
	localparam int INACT_LIMIT = 20;
	logic i_clk_sys = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] i_own_addr = 8'h11;
	logic i_ascii_mode = 1'b0;
	logic i_tcp_server_en = 1'b1;
	logic i_repeat_en = 1'b1;
	logic i_req_valid = 1'b0;
	mbsam_req_type i_req = '0;
	logic i_wr_valid = 1'b0;
	logic [15:0] i_wr_data = 16'h0000;
	logic i_rsp_ready = 1'b1;
	logic [7:0] i_scan_count = 8'h00;
	logic [15:0] i_mem_rdata;
	logic o_req_ready, o_wr_ready, o_rsp_valid, o_port_active;
	logic o_link_idle, o_exc_call, o_fwd, o_scan_ok;
	mbsam_mem_type o_mem;
	mbsam_rsp_type o_rsp;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int exc_n, fwd_n, act_n;
	mbsam_mem_type mq[$];
	mbsam_rsp_type rq[$];
	logic [7:0] sc [4] = '{8'h00, 8'h01, 8'h20, 8'h21};

	always #10 i_clk_sys = ~i_clk_sys;

	mbsam_mapper #(.INACT_LIMIT(INACT_LIMIT)) mbsam_mapper_inst (.i_clk_sys, .i_srst,
		.i_own_addr, .i_ascii_mode, .i_tcp_server_en, .i_repeat_en, .i_req_valid,
		.o_req_ready, .i_req, .i_wr_valid, .o_wr_ready, .i_wr_data, .o_mem, .i_mem_rdata,
		.o_rsp_valid, .i_rsp_ready, .o_rsp, .o_port_active, .o_link_idle, .o_exc_call,
		.o_fwd, .i_scan_count, .o_scan_ok);
	mbsam_space_model mbsam_space_model_inst (.i_clk_sys, .i_mem(o_mem), .o_rdata(i_mem_rdata));

	// monitor: collects accesses and answers, counts pulses, cuts hangs short
	always @(posedge i_clk_sys) begin
		cycles++;
		if (o_mem.en) mq.push_back(o_mem);
		if (o_rsp_valid && i_rsp_ready) rq.push_back(o_rsp);
		if (o_exc_call) exc_n++;
		if (o_fwd) fwd_n++;
		if (o_port_active) act_n++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// one request; beats for multi-writes; waits for the closing answer if one is due
	task automatic send(input logic tcp, input logic [7:0] unit, input logic [7:0] fc,
		input logic [15:0] st, input logic [15:0] cnt, input logic [15:0] val, input logic want);
		mq.delete();
		rq.delete();
		exc_n = 0;
		fwd_n = 0;
		act_n = 0;
		i_req_valid <= 1'b1;
		i_req <= '{tcp, unit, fc, st, cnt, val};
		@(posedge i_clk_sys);
		while (!o_req_ready) @(posedge i_clk_sys);
		i_req_valid <= 1'b0;
		if (fc == FC_WR_COILS || fc == FC_WR_REGS) begin
			for (int k = 0; k < cnt; k++) begin
				i_wr_valid <= 1'b1;
				i_wr_data <= 16'h5a30 + 16'(k);
				@(posedge i_clk_sys);
				while (!o_wr_ready) @(posedge i_clk_sys);
			end
			i_wr_valid <= 1'b0;
		end
		if (want) begin
			while (rq.size() == 0 || rq[$].kind == RK_DATA) @(posedge i_clk_sys);
		end else begin
			repeat (10) @(posedge i_clk_sys);
		end
		repeat (2) @(posedge i_clk_sys);
	endtask

	task automatic do_rd(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] cnt,
		input mbsam_space_type sp, input logic [12:0] ix);
		send(1'b0, 8'h11, fc, st, cnt, 16'h0000, 1'b1);
		check("accesses", mq.size(), cnt);
		check("answers", rq.size(), cnt + 1);
		for (int k = 0; k < cnt; k++) begin
			check("space", {mq[k].we, mq[k].space}, {1'b0, sp});
			check("index", mq[k].index, ix + 13'(k));
			check("data", rq[k].data, {sp, 12'(ix + 13'(k))});
		end
		check("done", {rq[cnt].kind, rq[cnt].data}, {RK_DONE, cnt});
		check("active", act_n > 0, 1'b1);
		$display("read test fc %h offset %0d finished", fc, st);
	endtask

	task automatic do_exc(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] cnt,
		input logic [15:0] val, input logic [15:0] code);
		send(1'b0, 8'h11, fc, st, cnt, val, 1'b1);
		check("exc kind", rq[0].kind, RK_EXC);
		check("exc code", rq[0].data, code);
		check("exc pulse", exc_n, 1);
		check("no access", mq.size(), 0);
		$display("exception test fc %h offset %0d finished", fc, st);
	endtask

	task automatic do_wr(input logic [7:0] fc, input logic [15:0] st, input logic [15:0] cnt,
		input logic [15:0] val, input mbsam_space_type sp, input logic [12:0] ix);
		logic [15:0] wd;
		send(1'b0, 8'h11, fc, st, cnt, val, 1'b1);
		check("accesses", mq.size(), cnt);
		for (int k = 0; k < cnt; k++) begin
			wd = (fc == FC_WR_COIL) ? 16'(val == COIL_ON) : (fc == FC_WR_REG) ? val :
				(fc == FC_WR_COILS) ? 16'(k % 2) : 16'h5a30 + 16'(k);
			check("wr place", {mq[k].we, mq[k].space, mq[k].index}, {1'b1, sp, ix + 13'(k)});
			check("wr data", mq[k].wdata, wd);
		end
		check("wr done", {rq.size(), rq[0].kind, rq[0].data}, {32'd1, RK_DONE, cnt});
		$display("write test fc %h offset %0d finished", fc, st);
	endtask

	task automatic do_route();
		send(1'b0, 8'h12, FC_RD_HOLD, 16'd0, 16'd1, 16'h0000, 1'b0);
		check("foreign silent", rq.size() + mq.size(), 0);
		check("forwarded", fwd_n, 1);
		i_repeat_en <= 1'b0;
		send(1'b0, 8'h12, FC_RD_HOLD, 16'd0, 16'd1, 16'h0000, 1'b0);
		check("not forwarded", fwd_n, 0);
		i_ascii_mode <= 1'b1;
		send(1'b1, 8'h99, FC_RD_HOLD, 16'd7, 16'd1, 16'h0000, 1'b1);
		check("tcp map", {mq[0].space, mq[0].index}, {SP_ANALOG_OUTPUT_WORDS, 13'd7});
		check("tcp flags", {rq[1].tcp, rq[1].ascii, rq[1].kind}, {2'b11, RK_DONE});
		i_tcp_server_en <= 1'b0;
		send(1'b1, 8'h11, FC_RD_HOLD, 16'd0, 16'd1, 16'h0000, 1'b0);
		check("tcp off", rq.size(), 0);
		i_tcp_server_en <= 1'b1;
		i_ascii_mode <= 1'b0;
		i_rsp_ready <= 1'b0;
		i_scan_count <= 8'h05;
		send(1'b0, 8'h11, FC_RD_HOLD, 16'd0, 16'd1, 16'h0000, 1'b0);
		check("answer held", {o_rsp_valid, o_rsp.kind, 32'(rq.size())}, {1'b1, RK_DATA, 32'd0});
		check("busy", {o_req_ready, o_wr_ready}, 2'b00);
		check("scan busy", o_scan_ok, 1'b1);
		i_rsp_ready <= 1'b1;
		while (rq.size() < 2) @(posedge i_clk_sys);
		check("after stall", rq[1].kind, RK_DONE);
		$display("routing test finished");
	endtask

	// reset in mid-answer: the stalled answer is dropped and the port goes idle
	task automatic do_reset();
		i_rsp_ready <= 1'b0;
		send(1'b0, 8'h11, FC_RD_HOLD, 16'd0, 16'd1, 16'h0000, 1'b0);
		check("stalled", o_rsp_valid, 1'b1);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		i_rsp_ready <= 1'b1;
		check("rst valid", o_rsp_valid, 1'b0);
		check("rst idle", {o_port_active, o_req_ready, o_link_idle}, 3'b010);
		$display("reset test finished");
	endtask

	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		repeat (INACT_LIMIT + 5) @(posedge i_clk_sys);
		check("link idle", o_link_idle, 1'b1);
		do_rd(FC_RD_HOLD, 16'd0, 16'd2, SP_ANALOG_OUTPUT_WORDS, 13'd0);
		check("link busy", o_link_idle, 1'b0);
		do_rd(FC_RD_HOLD, 16'd2999, 16'd1, SP_GEN_WORDS, 13'd2487);
		do_rd(FC_RD_HOLD, 16'd3000, 16'd1, SP_GEN_WORDS, 13'd0);
		do_rd(FC_RD_HOLD, 16'd14095, 16'd1, SP_GEN_WORDS, 13'd4095);
		do_rd(FC_RD_HOLD, 16'd6031, 16'd1, SP_GLOBAL_ANALOG_OUTPUT_WORDS, 13'd31);
		do_rd(FC_RD_INREG, 16'd511, 16'd1, SP_ANALOG_INPUT_WORDS, 13'd511);
		do_rd(FC_RD_INREG, 16'd3000, 16'd2, SP_GLOBAL_ANALOG_INPUT_WORDS, 13'd0);
		do_rd(FC_RD_INREG, 16'd4199, 16'd1, SP_SYSTEM_WORDS, 13'd199);
		do_rd(FC_RD_DISC, 16'd2047, 16'd1, SP_DISC_IN, 13'd2047);
		do_rd(FC_RD_DISC, 16'd3063, 16'd1, SP_GLOBAL_INPUT_BITS, 13'd63);
		do_rd(FC_RD_DISC, 16'd4012, 16'd1, SP_SYS_BITS, 13'd12);
		do_rd(FC_RD_COILS, 16'd0, 16'd3, SP_OUT_BITS, 13'd0);
		do_rd(FC_RD_COILS, 16'd5047, 16'd1, SP_INT_BITS, 13'd2047);
		do_rd(FC_RD_COILS, 16'd6000, 16'd1, SP_TEMP_BITS, 13'd0);
		do_rd(FC_RD_COILS, 16'd9063, 16'd1, SP_GLOBAL_OUTPUT_BITS, 13'd63);
		do_exc(8'h07, 16'd0, 16'd1, 16'h0000, EXC_ILL_FUNC);
		do_exc(FC_RD_DISC, 16'd5000, 16'd1, 16'h0000, EXC_ILL_ADDR);
		do_exc(FC_RD_DISC, 16'd4013, 16'd1, 16'h0000, EXC_ILL_ADDR);
		do_exc(FC_RD_COILS, 16'd2047, 16'd2, 16'h0000, EXC_ILL_ADDR);
		do_exc(FC_RD_HOLD, 16'd0, 16'd0, 16'h0000, EXC_ILL_VALUE);
		do_exc(FC_WR_COIL, 16'd0, 16'd1, 16'h1234, EXC_ILL_VALUE);
		do_wr(FC_WR_COIL, 16'd6000, 16'd1, COIL_ON, SP_TEMP_BITS, 13'd0);
		do_wr(FC_WR_COIL, 16'd3005, 16'd1, COIL_OFF, SP_INT_BITS, 13'd5);
		do_wr(FC_WR_COILS, 16'd9062, 16'd2, 16'h0000, SP_GLOBAL_OUTPUT_BITS, 13'd62);
		do_wr(FC_WR_REG, 16'd3000, 16'd1, 16'hbeef, SP_GEN_WORDS, 13'd0);
		do_wr(FC_WR_REGS, 16'd6030, 16'd2, 16'h0000, SP_GLOBAL_ANALOG_OUTPUT_WORDS, 13'd30);
		do_route();
		do_reset();
		// five-digit references: type in the top digit, one-based offset below it
		do_rd(FC_RD_HOLD, 16'(40513 - 40001), 16'd1, SP_GEN_WORDS, 13'd0);
		do_rd(FC_RD_DISC, 16'(13001 - 10001), 16'd1, SP_GLOBAL_INPUT_BITS, 13'd0);
		for (int k = 0; k < 4; k++) begin
			i_scan_count <= sc[k];
			repeat (2) @(posedge i_clk_sys);
			check("scan ok", o_scan_ok, 1'(k == 1 || k == 2));
		end
		$display("scan limit test finished");
		summarize();
	end
endmodule // tb_mbsam_mapper
`default_nettype wire
